// ==== hdl/pct_consts.vh ====
`ifndef PCT_CONSTS_VH
`define PCT_CONSTS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define PCT_OFF_CLK_EN    12'h000
`define PCT_OFF_MODE      12'h004
`define PCT_OFF_CNT_COND  12'h008
`define PCT_OFF_IRQ_EN    12'h00c
`define PCT_OFF_STATUS    12'h010
`define PCT_OFF_CLR_CTRL  12'h014
`define PCT_OFF_COUNT     12'h018
`define PCT_OFF_GEN_A     12'h01c
`define PCT_OFF_GEN_B     12'h020
`define PCT_OFF_IRQ_MASK  12'h024
`define PCT_OFF_IRQ_REQ   12'h028
`define PCT_OFF_PRIO_HI   12'h02c
`define PCT_OFF_PRIO_LO   12'h030

// ****************************************************************
// field positions
// ****************************************************************
`define PCT_BIT_CLK_EN    6
`define PCT_BIT_START     7
`define PCT_BIT_PHASE     1
`define PCT_BIT_OVIE      3
`define PCT_BIT_UDIE      2
`define PCT_BIT_OVF       1
`define PCT_BIT_UDF       0
`define PCT_BIT_CLR_HI    6
`define PCT_BIT_CLR_LO    5
`define PCT_BIT_IRQ       3

// ****************************************************************
// reset values and clear-source codes
// ****************************************************************
`define PCT_RST_BYTE      8'h00
`define PCT_RST_COUNT     16'h0000
`define PCT_RST_GEN       16'hffff
`define PCT_RST_MASK      1'b1
`define PCT_RST_PRIO      1'b1
`define PCT_CLR_NONE      2'b00
`define PCT_CLR_GEN_A     2'b01
`define PCT_CLR_GEN_B     2'b10

`endif

// ==== hdl/pct_timer.v ====
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pct_consts.vh"

module pct_timer #(
    parameter CNT_W = 16
) (
    input  wire              pclk,
    input  wire              presetn,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [11:0]       paddr,
    input  wire [31:0]       pwdata,
    output wire              pready,
    output reg  [31:0]       prdata,
    output wire              pslverr,
    input  wire              phase_a_input,
    input  wire              phase_b_input,
    output wire              timer_irq_out,
    output wire [1:0]        timer_irq_level,
    output wire [CNT_W-1:0]  timer_count_out
);

    // ****************************************************************
    // register state
    // ****************************************************************
    reg              module_clock_enable_q;
    reg  [7:0]       mode_q;
    reg  [7:0]       cnt_cond_q;
    reg  [1:0]       irq_en_q;
    reg              overflow_flag_q;
    reg              underflow_flag_q;
    reg  [7:0]       clr_ctrl_q;
    reg  [CNT_W-1:0] count_q;
    reg  [CNT_W-1:0] count_d;
    reg  [CNT_W-1:0] gen_a_q;
    reg  [CNT_W-1:0] gen_b_q;
    reg              timer_irq_mask_q;
    reg              timer_irq_request_flag_q;
    reg              prio_hi_q;
    reg              prio_lo_q;
    reg              phase_a_q;
    reg              phase_b_q;
    reg              step_up;
    reg              step_dn;
    reg              addr_ok;

    wire             wr_acc;
    wire             timer_wr;
    wire             running;
    wire             a_rise;
    wire             a_fall;
    wire             b_rise;
    wire             b_fall;
    wire             a_lvl;
    wire             b_lvl;
    wire             ovf_evt;
    wire             udf_evt;
    wire             clr_hit;
    wire [1:0]       clr_sel;
    wire             cnt_ld;

    // address match for a write access
    function wr_hit;
        input [11:0] addr;
        input [11:0] off;
        begin
            wr_hit = (addr == off);
        end
    endfunction

    // ****************************************************************
    // apb handshake
    // ****************************************************************
    // zero-wait slave; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign wr_acc  = psel & penable & pwrite & addr_ok;
    // timer registers accept writes only while the module clock runs
    assign timer_wr = wr_acc & module_clock_enable_q;

    // decode of mapped offsets
    always @* begin
        case (paddr)
            `PCT_OFF_CLK_EN, `PCT_OFF_MODE, `PCT_OFF_CNT_COND, `PCT_OFF_IRQ_EN,
            `PCT_OFF_STATUS, `PCT_OFF_CLR_CTRL, `PCT_OFF_COUNT, `PCT_OFF_GEN_A,
            `PCT_OFF_GEN_B, `PCT_OFF_IRQ_MASK, `PCT_OFF_IRQ_REQ, `PCT_OFF_PRIO_HI,
            `PCT_OFF_PRIO_LO: begin
                addr_ok = 1'b1;
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    // read data mux
    always @* begin
        prdata = 32'h0000_0000;
        case (paddr)
            `PCT_OFF_CLK_EN:   prdata[`PCT_BIT_CLK_EN] = module_clock_enable_q;
            `PCT_OFF_MODE:     prdata[7:0] = mode_q;
            `PCT_OFF_CNT_COND: prdata[7:0] = cnt_cond_q;
            `PCT_OFF_IRQ_EN: begin
                prdata[`PCT_BIT_OVIE] = irq_en_q[1];
                prdata[`PCT_BIT_UDIE] = irq_en_q[0];
            end
            `PCT_OFF_STATUS: begin
                prdata[`PCT_BIT_OVF] = overflow_flag_q;
                prdata[`PCT_BIT_UDF] = underflow_flag_q;
            end
            `PCT_OFF_CLR_CTRL: prdata[7:0] = clr_ctrl_q;
            `PCT_OFF_COUNT:    prdata[CNT_W-1:0] = count_q;
            `PCT_OFF_GEN_A:    prdata[CNT_W-1:0] = gen_a_q;
            `PCT_OFF_GEN_B:    prdata[CNT_W-1:0] = gen_b_q;
            `PCT_OFF_IRQ_MASK: prdata[`PCT_BIT_IRQ] = timer_irq_mask_q;
            `PCT_OFF_IRQ_REQ:  prdata[`PCT_BIT_IRQ] = timer_irq_request_flag_q;
            `PCT_OFF_PRIO_HI:  prdata[`PCT_BIT_IRQ] = prio_hi_q;
            `PCT_OFF_PRIO_LO:  prdata[`PCT_BIT_IRQ] = prio_lo_q;
            default:           prdata = 32'h0000_0000;
        endcase
    end

    // ****************************************************************
    // module clock enable
    // ****************************************************************
    // clock gate control stays writable so the timer can be woken
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            module_clock_enable_q <= 1'b0;
        end else if (wr_acc && wr_hit(paddr, `PCT_OFF_CLK_EN)) begin
            module_clock_enable_q <= pwdata[`PCT_BIT_CLK_EN];
        end
    end

    // ****************************************************************
    // timer configuration registers
    // ****************************************************************
    // held at reset values while the module clock is off
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q     <= `PCT_RST_BYTE;
            cnt_cond_q <= `PCT_RST_BYTE;
            irq_en_q   <= 2'b00;
            clr_ctrl_q <= `PCT_RST_BYTE;
            gen_a_q    <= `PCT_RST_GEN;
            gen_b_q    <= `PCT_RST_GEN;
        end else if (!module_clock_enable_q) begin
            mode_q     <= `PCT_RST_BYTE;
            cnt_cond_q <= `PCT_RST_BYTE;
            irq_en_q   <= 2'b00;
            clr_ctrl_q <= `PCT_RST_BYTE;
            gen_a_q    <= `PCT_RST_GEN;
            gen_b_q    <= `PCT_RST_GEN;
        end else if (timer_wr) begin
            if (wr_hit(paddr, `PCT_OFF_MODE)) begin
                mode_q <= pwdata[7:0];
            end
            if (wr_hit(paddr, `PCT_OFF_CNT_COND)) begin
                cnt_cond_q <= pwdata[7:0];
            end
            if (wr_hit(paddr, `PCT_OFF_IRQ_EN)) begin
                irq_en_q <= {pwdata[`PCT_BIT_OVIE], pwdata[`PCT_BIT_UDIE]};
            end
            if (wr_hit(paddr, `PCT_OFF_CLR_CTRL)) begin
                clr_ctrl_q <= {1'b0, pwdata[6:0]};
            end
            if (wr_hit(paddr, `PCT_OFF_GEN_A)) begin
                gen_a_q <= pwdata[CNT_W-1:0];
            end
            if (wr_hit(paddr, `PCT_OFF_GEN_B)) begin
                gen_b_q <= pwdata[CNT_W-1:0];
            end
        end
    end

    // ****************************************************************
    // phase input edge detection
    // ****************************************************************
    // previous sample of each phase input
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_a_q <= 1'b0;
            phase_b_q <= 1'b0;
        end else begin
            phase_a_q <= phase_a_input;
            phase_b_q <= phase_b_input;
        end
    end

    assign a_rise = phase_a_input & ~phase_a_q;
    assign a_fall = ~phase_a_input & phase_a_q;
    assign b_rise = phase_b_input & ~phase_b_q;
    assign b_fall = ~phase_b_input & phase_b_q;
    assign a_lvl  = phase_a_input;
    assign b_lvl  = phase_b_input;

    // ****************************************************************
    // count conditions
    // ****************************************************************
    assign running = module_clock_enable_q & mode_q[`PCT_BIT_START];

    // enabled up and down conditions; simultaneous up and down cancel
    always @* begin
        step_up = 1'b0;
        step_dn = 1'b0;
        if (running) begin
            if (mode_q[`PCT_BIT_PHASE]) begin
                step_up = (cnt_cond_q[7] & ~a_lvl & b_rise)
                        | (cnt_cond_q[6] &  b_lvl & a_rise)
                        | (cnt_cond_q[5] &  a_lvl & b_fall)
                        | (cnt_cond_q[4] & ~b_lvl & a_fall);
                step_dn = (cnt_cond_q[3] &  b_lvl & a_fall)
                        | (cnt_cond_q[2] & ~a_lvl & b_fall)
                        | (cnt_cond_q[1] & ~b_lvl & a_rise)
                        | (cnt_cond_q[0] &  a_lvl & b_rise);
            end else begin
                step_up = 1'b1; // plain up-count on the module clock
            end
        end
    end

    // ****************************************************************
    // counter
    // ****************************************************************
    assign clr_sel = {clr_ctrl_q[`PCT_BIT_CLR_HI], clr_ctrl_q[`PCT_BIT_CLR_LO]};
    // match on the general register picked by clr_sel clears instead of stepping
    assign clr_hit = running &
                     (((clr_sel == `PCT_CLR_GEN_A) && (count_q == gen_a_q)) |
                      ((clr_sel == `PCT_CLR_GEN_B) && (count_q == gen_b_q)));
    // a software load replaces the step, so it raises no wrap flag either
    assign cnt_ld  = timer_wr & wr_hit(paddr, `PCT_OFF_COUNT);
    assign ovf_evt = ~cnt_ld & ~clr_hit & step_up & ~step_dn & (&count_q);
    assign udf_evt = ~cnt_ld & ~clr_hit & step_dn & ~step_up & ~(|count_q);

    // next count value
    always @* begin
        count_d = count_q;
        if (cnt_ld) begin
            count_d = pwdata[CNT_W-1:0];
        end else if (clr_hit) begin
            count_d = {CNT_W{1'b0}};
        end else if (step_up && !step_dn) begin
            count_d = count_q + 1'b1;
        end else if (step_dn && !step_up) begin
            count_d = count_q - 1'b1;
        end
    end

    // count register, reset while the module clock is off
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= `PCT_RST_COUNT;
        end else if (!module_clock_enable_q) begin
            count_q <= `PCT_RST_COUNT;
        end else begin
            count_q <= count_d;
        end
    end

    // ****************************************************************
    // overflow and underflow flags
    // ****************************************************************
    // sticky; a write of 0 clears, a new event in that cycle wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_flag_q  <= 1'b0;
            underflow_flag_q <= 1'b0;
        end else if (!module_clock_enable_q) begin
            overflow_flag_q  <= 1'b0;
            underflow_flag_q <= 1'b0;
        end else begin
            if (ovf_evt) begin
                overflow_flag_q <= 1'b1;
            end else if (timer_wr && wr_hit(paddr, `PCT_OFF_STATUS) && !pwdata[`PCT_BIT_OVF]) begin
                overflow_flag_q <= 1'b0;
            end
            if (udf_evt) begin
                underflow_flag_q <= 1'b1;
            end else if (timer_wr && wr_hit(paddr, `PCT_OFF_STATUS) && !pwdata[`PCT_BIT_UDF]) begin
                underflow_flag_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // interrupt request, mask and priority
    // ****************************************************************
    // request flag: set by an enabled event, cleared by writing 0
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_irq_request_flag_q <= 1'b0;
        end else if ((ovf_evt && irq_en_q[1]) || (udf_evt && irq_en_q[0])) begin
            timer_irq_request_flag_q <= 1'b1;
        end else if (wr_acc && wr_hit(paddr, `PCT_OFF_IRQ_REQ) && !pwdata[`PCT_BIT_IRQ]) begin
            timer_irq_request_flag_q <= 1'b0;
        end
    end

    // mask and priority bits
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_irq_mask_q <= `PCT_RST_MASK;
            prio_hi_q        <= `PCT_RST_PRIO;
            prio_lo_q        <= `PCT_RST_PRIO;
        end else if (wr_acc) begin
            if (wr_hit(paddr, `PCT_OFF_IRQ_MASK)) begin
                timer_irq_mask_q <= pwdata[`PCT_BIT_IRQ];
            end
            if (wr_hit(paddr, `PCT_OFF_PRIO_HI)) begin
                prio_hi_q <= pwdata[`PCT_BIT_IRQ];
            end
            if (wr_hit(paddr, `PCT_OFF_PRIO_LO)) begin
                prio_lo_q <= pwdata[`PCT_BIT_IRQ];
            end
        end
    end

    // pending request goes out only while unmasked
    assign timer_irq_out   = timer_irq_request_flag_q & ~timer_irq_mask_q;
    assign timer_irq_level = {prio_hi_q, prio_lo_q};
    assign timer_count_out = count_q;

endmodule

`default_nettype wire

// ==== dv/pct_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pct_consts.vh"
// ****************************************************************
// port checker for the timer
// ****************************************************************
module pct_checker #(
    parameter CNT_W = 16
) (
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [11:0]      paddr,
    input wire logic [31:0]      pwdata,
    input wire logic             pready,
    input wire logic [31:0]      prdata,
    input wire logic             pslverr,
    input wire logic             phase_a_input,
    input wire logic             phase_b_input,
    input wire logic             timer_irq_out,
    input wire logic [1:0]       timer_irq_level,
    input wire logic [CNT_W-1:0] timer_count_out
);
    logic en_q;
    wire  wr = psel && penable && pwrite;
    wire  wa = wr && paddr == `PCT_OFF_COUNT;
    wire  wm = wr && paddr == `PCT_OFF_IRQ_MASK;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // module clock enable as software last wrote it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) en_q <= 1'h0;
        else if (wr && paddr == `PCT_OFF_CLK_EN) en_q <= pwdata[6];
    end
    chk_off_zero: assert property (!en_q && !$past(en_q) |-> timer_count_out == '0)
        else $error("count not zero while clock off");
    chk_map_ok: assert property (psel && penable && paddr <= `PCT_OFF_PRIO_LO && paddr[1:0] == 2'h0 |->
        pready && !pslverr)
        else $error("mapped access refused");
    chk_cnt_load: assert property (wa && en_q |=> timer_count_out == $past(pwdata[CNT_W-1:0]))
        else $error("counter write not loaded");
    chk_cnt_step: assert property (!$stable(timer_count_out) && !$past(wa) |->
        timer_count_out == '0 || timer_count_out == $past(timer_count_out) + 1'b1 ||
        timer_count_out == $past(timer_count_out) - 1'b1)
        else $error("counter moved by more than one");
    chk_prio_hi: assert property (wr && paddr == `PCT_OFF_PRIO_HI |=>
        timer_irq_level[1] == $past(pwdata[3]))
        else $error("priority high bit not taken");
    chk_prio_lo: assert property (wr && paddr == `PCT_OFF_PRIO_LO |=>
        timer_irq_level[0] == $past(pwdata[3]))
        else $error("priority low bit not taken");
    chk_mask_block: assert property (wm && pwdata[3] |=> !timer_irq_out[*2])
        else $error("masked request still out");
    chk_irq_cause: assert property ($rose(timer_irq_out) |->
        $past(wm) || $past(timer_count_out) == ~timer_count_out)
        else $error("request without wrap or unmask");
    chk_req_sticky: assert property ($fell(timer_irq_out) |->
        $past(wm && pwdata[3] || wr && paddr == `PCT_OFF_IRQ_REQ && !pwdata[3]))
        else $error("request dropped on its own");
    cover property ($rose(timer_irq_out));
    cover property (wa && en_q);
    cover property ($past(timer_count_out) == '0 && timer_count_out == '1);
endmodule
`default_nettype wire

// ==== dv/pct_quad_src.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// two-phase source model
// ****************************************************************
module pct_quad_src (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic go,
    input  wire logic fwd,
    output logic      phase_a,
    output logic      phase_b
);
    logic [1:0] pos_q;
    // gray walk {a,b}: 00,10,11,01 forward, one edge per move
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) pos_q <= 2'h0;
        else if (go) pos_q <= fwd ? pos_q + 2'h1 : pos_q - 2'h1;
    end
    assign phase_a = pos_q[1] ^ pos_q[0];
    assign phase_b = pos_q[1];
endmodule
`default_nettype wire

// ==== dv/tb_phase_counting_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pct_consts.vh"
// ****************************************************************
// testbench
// ****************************************************************
module tb_phase_counting_timer;
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, go = 1'h0, fwd = 1'h0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, rdat, prdata, seed = 32'h2bdb2ca5;
    logic        pready, pslverr, serr, qa, qb, irq;
    logic [1:0]  lvl;
    logic [15:0] cnt, exp_cnt;
    logic [7:0]  m;
    int          miscompares = 0, cmp_count = 0, i, j;
    pct_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .phase_a_input(qa), .phase_b_input(qb), .timer_irq_out(irq), .timer_irq_level(lvl), .timer_count_out(cnt));
    pct_quad_src u_src (.pclk(pclk), .presetn(presetn), .go(go), .fwd(fwd), .phase_a(qa), .phase_b(qb));
    always #12.5 pclk = ~pclk;
    task automatic wrap_up();
        if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask
    // one apb transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        rdat = prdata;
        serr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        // let the landing edge's register updates settle before outputs are looked at
        @(negedge pclk);
        if (n >= 50) begin
            miscompares++;
            wrap_up();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'h0, a, '0);
        chk($sformatf("reg %h", a), e, rdat);
    endtask
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // count change for a move from {a,b}=p to n under enables e
    function automatic logic [15:0] dlt(input logic [1:0] p, input logic [1:0] n, input logic [7:0] e);
        logic ar, af, br, bf;
        ar = !p[1] && n[1];
        af = p[1] && !n[1];
        br = !p[0] && n[0];
        bf = p[0] && !n[0];
        if (e[7] && !n[1] && br || e[6] && n[0] && ar || e[5] && n[1] && bf || e[4] && !n[0] && af) return 16'h0001;
        if (e[3] && n[0] && af || e[2] && !n[1] && bf || e[1] && !n[0] && ar || e[0] && n[1] && br) return 16'hffff;
        return 16'h0000;
    endfunction
    // one source move, then let the counter settle
    task automatic step(input logic f, input logic [7:0] e);
        logic [1:0] p;
        p = {qa, qb};
        @(posedge pclk);
        go <= 1'h1;
        fwd <= f;
        @(posedge pclk);
        go <= 1'h0;
        repeat (3) @(posedge pclk);
        exp_cnt = exp_cnt + dlt(p, {qa, qb}, e);
    endtask
    // main sequence
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        rd(`PCT_OFF_IRQ_MASK, 32'h8);
        chk("level", 32'h3, lvl);
        wr(`PCT_OFF_COUNT, 32'h1234);
        rd(`PCT_OFF_COUNT, 32'h0);
        apb(1'h0, 12'hffc, '0);
        chk("slverr", 32'h1, serr);
        wr(`PCT_OFF_CLK_EN, 32'h40);
        wr(`PCT_OFF_COUNT, 32'h1234);
        rd(`PCT_OFF_COUNT, 32'h1234);
        wr(`PCT_OFF_CNT_COND, 32'hff);
        exp_cnt = 16'h1234;
        step(1'h1, 8'h00);
        chk("held", exp_cnt, cnt);
        wr(`PCT_OFF_MODE, 32'h82);
        for (i = 0; i < 60; i++) begin
            if (i % 12 == 0) begin
                m = 8'(rnd());
                wr(`PCT_OFF_CNT_COND, m);
            end
            step(1'(rnd()), m);
            chk("count", exp_cnt, cnt);
        end
        wr(`PCT_OFF_CNT_COND, 32'hff);
        wr(`PCT_OFF_IRQ_EN, 32'h4);
        wr(`PCT_OFF_IRQ_MASK, 32'h0);
        wr(`PCT_OFF_COUNT, 32'h0);
        step(1'h1, 8'hff);
        chk("wrap", 32'hffff, cnt);
        rd(`PCT_OFF_STATUS, 32'h1);
        chk("irq", 32'h1, irq);
        wr(`PCT_OFF_IRQ_MASK, 32'h8);
        chk("masked", 32'h0, irq);
        rd(`PCT_OFF_IRQ_REQ, 32'h8);
        wr(`PCT_OFF_IRQ_REQ, 32'h0);
        rd(`PCT_OFF_IRQ_REQ, 32'h0);
        wr(`PCT_OFF_STATUS, 32'h0);
        step(1'h0, 8'hff);
        chk("ovf", 32'h0, cnt);
        rd(`PCT_OFF_STATUS, 32'h2);
        rd(`PCT_OFF_IRQ_REQ, 32'h0);
        for (i = 0; i < 4; i++) begin
            wr(`PCT_OFF_PRIO_HI, (i >> 1) << 3);
            wr(`PCT_OFF_PRIO_LO, (i & 1) << 3);
            chk("level", i, lvl);
        end
        // plain up-count: three edges pass between the two mode writes landing
        wr(`PCT_OFF_COUNT, 32'h10);
        wr(`PCT_OFF_MODE, 32'h80);
        wr(`PCT_OFF_MODE, 32'h82);
        rd(`PCT_OFF_COUNT, 32'h13);
        // only the selected general register holds the match value
        for (j = 0; j < 3; j++) begin
            wr(`PCT_OFF_GEN_A, j == 1 ? 32'h5 : 32'h6);
            wr(`PCT_OFF_GEN_B, j == 2 ? 32'h5 : 32'h6);
            wr(`PCT_OFF_CLR_CTRL, j << 5);
            wr(`PCT_OFF_COUNT, 32'h4);
            step(1'h0, 8'hff);
            chk("clear", j == 0 ? 32'h5 : 32'h0, cnt);
        end
        wr(`PCT_OFF_CLK_EN, 32'h0);
        rd(`PCT_OFF_MODE, 32'h0);
        chk("off", 32'h0, cnt);
        wrap_up();
    end
endmodule
bind pct_timer pct_checker #(.CNT_W(CNT_W)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .phase_a_input(phase_a_input), .phase_b_input(phase_b_input),
    .timer_irq_out(timer_irq_out), .timer_irq_level(timer_irq_level), .timer_count_out(timer_count_out));
`default_nettype wire
